// ===== shared/pin_change_regs.svh
// Register offsets, reset values, field positions and masks of the
// pin-change block. Included by the pin_change_interrupt module only.
`ifndef PIN_CHANGE_REGS_SVH
`define PIN_CHANGE_REGS_SVH

`define OFS_PORT_A_REGISTER      4'h0
`define OFS_PORT_B_REGISTER      4'h1
`define OFS_PC_ENABLE_PORT_A     4'h2
`define OFS_PC_ENABLE_PORT_B     4'h3
`define OFS_INTERRUPT_CONTROL    4'h4
`define OFS_ANALOG_SELECT_PORT_A 4'h5
`define OFS_ANALOG_SELECT_PORT_B 4'h6
`define OFS_CONFIG               4'h7
`define OFS_IRQ_STATUS           4'h8
`define OFS_IRQ_MASK             4'h9

`define RST_PC_ENABLE            8'h00
`define RST_INTERRUPT_CONTROL    8'h00
`define RST_ANALOG_SELECT        8'h00
`define RST_CONFIG               8'h00
`define RST_IRQ_MASK             8'h00

`define BIT_CHANGE_FLAG          0
`define BIT_CHANGE_IE            3
`define BIT_CFG_MASTER_CLEAR_A5  0
`define BIT_CFG_SMALL_PACKAGE    1
`define MASTER_CLEAR_PIN_INDEX   5

`define IRQ_BIT_CHANGE           0
`define IRQ_BIT_FLAG_CLEARED     1

`define SMALL_PKG_B_MASK         8'h0F

`endif

// ===== shared/pin_change_pkg.sv
// Types shared by the pin-change block and its bench.
// Assumes an 8-bit register data path.
package pin_change_pkg;

    typedef logic [7:0] byte_t;

    typedef struct packed {
        logic [3:0] addr;
        byte_t      wdata;
        logic       wr;
        logic       rd;
    } bus_req_s;

    typedef struct packed {
        byte_t port_a;
        byte_t port_b;
    } pins_s;

endpackage

// ===== design/pin_sync.sv
// Two-stage synchroniser for a vector of asynchronous pin levels.
// Assumes the pins are unrelated to ref_clk.
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    if (WIDTH < 1) begin
        $error("pin_sync WIDTH must be positive");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_s;

    sync_state_s state_reg;
    sync_state_s state_next;

    always_comb begin
        state_next        = state_reg;
        state_next.meta   = async_in;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stable;

endmodule

// ===== design/pin_change_interrupt.sv
// Pin-change interrupt logic for two 8-bit ports with register access.
// Assumes a single-cycle strobe bus; rst is power-on reset, master_clear a
// synchronous master-clear that spares the comparison latch.
// Notes on behaviour
// [RULE_01] One enable bit per pin; 1 enables; small package lacks B7..B4.
// [RULE_02] Power-on reset clears all per-pin enable bits.
// [RULE_03] Port A pin 5 never detects while it serves as master clear.
// [RULE_04] Each enabled pin compares against the level latched at last read.
// [RULE_05] OR of all enabled mismatches sets change flag, bit 0.
// [RULE_06] Interrupt only when bit 3 set; flag still sets when clear. The irq output ignores bit 3; irq_mask bits 0 and 1 gate it.
// [RULE_07] A persisting mismatch keeps setting the flag over software clears.
// [RULE_08] Port read then flag clear ends the mismatch; flag stays clear.
// [RULE_09] Port write then flag clear also ends the mismatch.
// [RULE_10] Master clear keeps the latch; flag re-sets on a live mismatch.
// [RULE_11] A change during a port access may be missed.
// [RULE_12] A detected change wakes the core while bit 3 is set.
// [RULE_13] Analog-selected pins take no part in change detection.
// [RULE_14] Port read reloads the whole latch; pins are synchronised first.
`timescale 1ns/1ns
`include "pin_change_regs.svh"
module pin_change_interrupt
    import pin_change_pkg::*;
#(
    parameter int PORT_WIDTH = 8
) (
    input  wire logic     ref_clk,
    input  wire logic     rst,
    input  wire logic     master_clear,
    input  wire pins_s    pins,
    input  wire logic     sleeping,
    input  wire bus_req_s bus,
    output byte_t         rdata,
    output logic          change_irq,
    output logic          wake,
    output logic          irq
);

    // The register map is fixed at eight pins per port
    if (PORT_WIDTH != 8) begin
        $error("PORT_WIDTH must be 8");
    end

    typedef struct packed {
        byte_t latch_a;
        byte_t latch_b;
        byte_t en_a;
        byte_t en_b;
        byte_t ana_a;
        byte_t ana_b;
        byte_t cfg;
        logic  change_flag;
        logic  change_ie;
        byte_t irq_status;
        byte_t irq_mask;
        byte_t rdata;
        logic  change_irq;
        logic  wake;
        logic  irq;
    } state_s;

    state_s state_reg;
    state_s state_next;
    logic [15:0] pins_sync;

    pin_sync #(.WIDTH(16)) u_sync (                                // RULE_14
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in ({pins.port_b, pins.port_a}),
        .sync_out (pins_sync)
    );

    function automatic logic is_sel(input logic [3:0] a,
                                    input logic [3:0] ofs);
        return a == ofs;
    endfunction

    function automatic byte_t b_mask(input byte_t cfg);
        return cfg[`BIT_CFG_SMALL_PACKAGE] ? `SMALL_PKG_B_MASK : 8'hFF;
    endfunction

    byte_t pin_a;
    byte_t pin_b;
    byte_t live_a;
    byte_t live_b;
    logic  mismatch;
    logic [15:0] live_all;
    logic [15:0] latch_all;
    logic [15:0] pin_miss;
    logic  port_rd;
    logic  port_wr;
    logic  port_acc;
    logic  ctl_wr;
    logic  flag_set;
    byte_t ctl_value;
    byte_t events;

    always_comb begin
        live_a = state_reg.en_a & ~state_reg.ana_a;                   // RULE_13
        if (state_reg.cfg[`BIT_CFG_MASTER_CLEAR_A5]) begin
            live_a[`MASTER_CLEAR_PIN_INDEX] = 1'b0;                   // RULE_03
        end
        live_b = state_reg.en_b & ~state_reg.ana_b
               & b_mask(state_reg.cfg);                               // RULE_01
    end

    assign live_all  = {live_b, live_a};
    assign latch_all = {state_reg.latch_b, state_reg.latch_a};

    // One comparator per pin against its latched level
    for (genvar i = 0; i < 16; i++) begin                            // RULE_04
        assign pin_miss[i] = live_all[i] & (pins_sync[i] ^ latch_all[i]);
    end

    assign mismatch = |pin_miss;                                      // RULE_05

    always_comb begin
        pin_a  = pins_sync[7:0];
        pin_b  = pins_sync[15:8];
        port_rd  = bus.rd & (is_sel(bus.addr, `OFS_PORT_A_REGISTER)
                 | is_sel(bus.addr, `OFS_PORT_B_REGISTER));
        port_wr  = bus.wr & (is_sel(bus.addr, `OFS_PORT_A_REGISTER)
                 | is_sel(bus.addr, `OFS_PORT_B_REGISTER));
        port_acc = port_rd | port_wr;
        ctl_wr   = bus.wr & is_sel(bus.addr, `OFS_INTERRUPT_CONTROL);
        // Detection is skipped during a port access
        flag_set = mismatch & ~port_acc;                              // RULE_11
        ctl_value = '0;
        ctl_value[`BIT_CHANGE_FLAG] = state_reg.change_flag;
        ctl_value[`BIT_CHANGE_IE]   = state_reg.change_ie;
    end

    always_comb begin
        state_next = state_reg;
        events = '0;
        state_next.rdata = '0;

        // Port read or write refreshes the latch       RULE_08 RULE_09 RULE_14
        if (port_acc) begin
            state_next.latch_a = pin_a;
            state_next.latch_b = pin_b & b_mask(state_reg.cfg);
        end

        if (bus.wr) begin
            case (bus.addr)
                `OFS_PC_ENABLE_PORT_A: state_next.en_a = bus.wdata;  // RULE_01
                `OFS_PC_ENABLE_PORT_B:
                    state_next.en_b = bus.wdata & b_mask(state_reg.cfg);
                `OFS_INTERRUPT_CONTROL: begin
                    state_next.change_ie   = bus.wdata[`BIT_CHANGE_IE];
                    state_next.change_flag = bus.wdata[`BIT_CHANGE_FLAG];
                end
                `OFS_ANALOG_SELECT_PORT_A: state_next.ana_a = bus.wdata;
                `OFS_ANALOG_SELECT_PORT_B: state_next.ana_b = bus.wdata;
                `OFS_CONFIG: state_next.cfg = bus.wdata;
                `OFS_IRQ_MASK: state_next.irq_mask = bus.wdata;
                default: ;
            endcase
        end

        if (ctl_wr & state_reg.change_flag
            & ~bus.wdata[`BIT_CHANGE_FLAG]) begin
            events[`IRQ_BIT_FLAG_CLEARED] = 1'b1;
        end

        // Set wins over a software clear                     RULE_07 RULE_10
        if (flag_set) begin
            state_next.change_flag = 1'b1;                          // RULE_05
            if (!state_reg.change_flag) begin
                events[`IRQ_BIT_CHANGE] = 1'b1;
            end
        end

        if (bus.rd) begin
            case (bus.addr)
                `OFS_PORT_A_REGISTER:      state_next.rdata = pin_a;
                `OFS_PORT_B_REGISTER:
                    state_next.rdata = pin_b & b_mask(state_reg.cfg);
                `OFS_PC_ENABLE_PORT_A:     state_next.rdata = state_reg.en_a;
                `OFS_PC_ENABLE_PORT_B:     state_next.rdata = state_reg.en_b;
                `OFS_INTERRUPT_CONTROL:    state_next.rdata = ctl_value;
                `OFS_ANALOG_SELECT_PORT_A: state_next.rdata = state_reg.ana_a;
                `OFS_ANALOG_SELECT_PORT_B: state_next.rdata = state_reg.ana_b;
                `OFS_CONFIG:               state_next.rdata = state_reg.cfg;
                `OFS_IRQ_STATUS: state_next.rdata = state_reg.irq_status;
                `OFS_IRQ_MASK:   state_next.rdata = state_reg.irq_mask;
                default:         state_next.rdata = '0;
            endcase
        end

        // Status read clears, but a same-cycle event survives
        if (bus.rd && is_sel(bus.addr, `OFS_IRQ_STATUS)) begin
            state_next.irq_status = events;
        end else begin
            state_next.irq_status = state_reg.irq_status | events;
        end

        // Master clear resets control except cfg but spares the latch   RULE_10
        if (master_clear) begin
            state_next.en_a        = `RST_PC_ENABLE;
            state_next.en_b        = `RST_PC_ENABLE;
            state_next.ana_a       = `RST_ANALOG_SELECT;
            state_next.ana_b       = `RST_ANALOG_SELECT;
            state_next.change_ie   = 1'b0;
            state_next.change_flag = flag_set;
            state_next.irq_status  = '0;
            state_next.irq_mask    = `RST_IRQ_MASK;
            state_next.rdata       = '0;
        end

        state_next.change_irq = state_next.change_flag
                              & state_next.change_ie;               // RULE_06
        state_next.wake = state_next.change_irq & sleeping;         // RULE_12
        state_next.irq  = |(state_next.irq_status & state_next.irq_mask);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg          <= '0;
            state_reg.en_a     <= `RST_PC_ENABLE;                   // RULE_02
            state_reg.en_b     <= `RST_PC_ENABLE;
            state_reg.ana_a    <= `RST_ANALOG_SELECT;
            state_reg.ana_b    <= `RST_ANALOG_SELECT;
            state_reg.cfg      <= `RST_CONFIG;
            state_reg.irq_mask <= `RST_IRQ_MASK;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata      = state_reg.rdata;
    assign change_irq = state_reg.change_irq;
    assign wake       = state_reg.wake;
    assign irq        = state_reg.irq;

endmodule

// ===== bench/pin_change_assertions.sv
// Port checker for pin_change_interrupt.
// Assumes a bind to the top module.
`timescale 1ns/1ns
module pin_change_assertions
    import pin_change_pkg::*;
(
    input wire logic     ref_clk,
    input wire logic     rst,
    input wire logic     master_clear,
    input wire pins_s    pins,
    input wire logic     sleeping,
    input wire bus_req_s bus,
    input wire byte_t    rdata,
    input wire logic     change_irq,
    input wire logic     wake,
    input wire logic     irq
);
    logic ie_reg;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            ie_reg <= 1'b0;
        else if (master_clear || (bus.wr && bus.addr == 4'h4))
            ie_reg <= !master_clear && bus.wdata[3];
    end
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_reset_quiet: assert property ($past(rst) |->
        !change_irq && !irq && !wake) else $error("active after reset");
    a_rdata_idle: assert property (!$past(bus.rd) |->
        rdata == 8'h00) else $error("rdata without read");
    a_unmapped_zero: assert property (bus.rd && bus.addr > 4'h9 |=>
        rdata == 8'h00) else $error("unmapped read not zero");
    a_ie_gates_irq: assert property (change_irq |->
        ie_reg || $past(ie_reg)) else $error("irq without enable");
    a_ie_readback: assert property (bus.rd && bus.addr == 4'h4 |=>
        rdata[3] == $past(ie_reg)) else $error("enable bit lost");
    a_wake_asleep: assert property (wake |->
        $past(sleeping)) else $error("wake while awake");
    a_wake_cause: assert property (change_irq && $past(sleeping) |->
        wake) else $error("no wake");
    a_clear_cause: assert property ($fell(change_irq) |->
        $past(bus.wr) || $past(bus.wr, 2) || $past(master_clear) ||
        $past(master_clear, 2)) else $error("irq fell without cause");
    a_master_clear: assert property (master_clear |->
        ##1 !change_irq && !irq) else $error("irq after master clear");
    c_change: cover property ($rose(change_irq));
    c_wake: cover property ($rose(wake));
    c_irq: cover property ($rose(irq));
endmodule

bind pin_change_interrupt pin_change_assertions chk (
    .ref_clk(ref_clk), .rst(rst), .master_clear(master_clear),
    .pins(pins), .sleeping(sleeping), .bus(bus), .rdata(rdata),
    .change_irq(change_irq), .wake(wake), .irq(irq));

// ===== bench/pin_model.sv
// Far-side pin driver.
// Assumes levels are asked for just after a clock edge.
`timescale 1ns/1ns
module pin_model
    import pin_change_pkg::*;
(
    input  wire pins_s want,
    output pins_s      pins
);
    // Lands mid-cycle, unrelated to the sampling edge
    assign #37 pins = want;
endmodule

// ===== bench/pin_change_interrupt_tb_top.sv
// Bench for pin_change_interrupt.
// Assumes pin_model and the bound checker.
`timescale 1ns/1ns
module pin_change_interrupt_tb_top import pin_change_pkg::*; ();
    logic     ref_clk, rst, master_clear, sleeping;
    bus_req_s bus;
    pins_s    want, pins;
    byte_t    rdata, v, latch;
    logic     change_irq, wake, irq;
    int       failures = 0;
    int       samples_checked = 0;
    int       seed;
    logic [15:0] prog [$] = {
        16'h0201, 16'h0408, 16'h0901, 16'h2001, 16'h9000,
        16'h1409, 16'h8001, 16'h0408, 16'h9000, 16'h1409,
        16'h1001, 16'h0408, 16'h9000, 16'h1408, 16'h6000,
        16'h1803, 16'h1800, 16'h8000,
        16'h4001, 16'h2000, 16'h9000, 16'h7001,
        16'h0100, 16'h0408, 16'h9000, 16'h6000, 16'h4000,
        16'h0400, 16'h2001, 16'h9000, 16'h6000, 16'h1401,
        16'h5001, 16'hE000, 16'h5000, 16'hE000, 16'h1401, 16'h1200,
        16'h0701, 16'h0220, 16'h0400, 16'h2021, 16'h9000, 16'h1400,
        16'h0502, 16'h0202, 16'h2023, 16'h9000, 16'h1400,
        16'h0702, 16'h03FF, 16'h30F0, 16'h9000, 16'h1400,
        16'h0700, 16'h11F0, 16'h0400
    };

    pin_model pm (.want(want), .pins(pins));
    pin_change_interrupt dut (.ref_clk(ref_clk), .rst(rst),
        .master_clear(master_clear), .pins(pins), .sleeping(sleeping),
        .bus(bus), .rdata(rdata), .change_irq(change_irq),
        .wake(wake), .irq(irq));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = !ref_clk;
    end

    task automatic check(input string s, input byte_t seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
        end
    endtask

    // Flag expected from enabled pins that differ from the latch
    function automatic logic flag_exp(input byte_t pin, old, en);
        return |((pin ^ old) & en);
    endfunction

    // Reads compare the answer with d
    task automatic io(input logic w, input logic [3:0] a, input byte_t d);
        bus <= '{a, d, w, !w};
        @(posedge ref_clk);
        bus <= '0;
        #10 if (!w) check("rdata", rdata, d);
        @(posedge ref_clk);
    endtask

    task automatic settle();
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic step(input logic [15:0] op);
        case (op[15:12])
            4'h0: io(1'b1, op[11:8], op[7:0]);
            4'h1: io(1'b0, op[11:8], op[7:0]);
            4'h2: want.port_a <= op[7:0];
            4'h3: want.port_b <= op[7:0];
            4'h4: sleeping <= op[0];
            4'h5: master_clear <= op[0];
            4'h6: begin
                #10 check("change_irq", change_irq, op[7:0]);
                @(posedge ref_clk);
            end
            4'h7: begin
                #10 check("wake", wake, op[7:0]);
                @(posedge ref_clk);
            end
            4'h8: begin
                #10 check("irq", irq, op[7:0]);
                @(posedge ref_clk);
            end
            4'h9: settle();
            default: @(posedge ref_clk);
        endcase
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        seed = 9;
        latch = 8'hF0;
        {rst, master_clear, sleeping} = 3'b100;
        bus = '0;
        want = '0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int a = 0; a < 16; a++)
            io(1'b0, 4'(a), 8'h00);
        $display("test reset values done");
        foreach (prog[i])
            step(prog[i]);
        $display("test sequences done");
        for (int i = 0; i < 8; i++) begin
            v = byte_t'($random(seed));
            want.port_b <= v;
            settle();
            io(1'b0, 4'h4, {7'h00, flag_exp(v, latch, 8'h0F)});
            io(1'b0, 4'h1, v);
            latch = v;
            io(1'b1, 4'h4, 8'h00);
        end
        $display("test random pins done");
        final_report();
    end
endmodule
